/* design/root_port_defines.svh */
// Constants for the root-port error and PME register block
// Behaviour
// - PME message with enable raises interrupt
// - Enable rising while status set raises interrupt
// - Fatal message gives system error if enabled
// - Nonfatal message gives system error if enabled
// - Correctable message gives system error if enabled
// - PME message sets PME status flag
// - Status cleared only by writing one
// - PME while status set sets pending unless status is cleared that cycle
// - Pending clears when nothing remains pending
// - Last PME requester ID recorded read-only
// - Posted header credits read 0Ch
// - Posted data credits read 030h
// - Nonposted header credits read 08h
// - Nonposted data credits read 001h
`ifndef ROOT_PORT_DEFINES_SVH
`define ROOT_PORT_DEFINES_SVH
`define OFS_RP_CONTROL      12'h0080
`define OFS_RP_STATUS       12'h0084
`define OFS_POSTED_CREDIT   12'h00C4
`define OFS_NONPOSTED_CRED  12'h00C8
`define OFS_ENH_CAP_HDR     12'h0100
`define BIT_CORR_ENABLE     0
`define BIT_NONFATAL_ENABLE 1
`define BIT_FATAL_ENABLE    2
`define BIT_PME_INT_ENABLE  3
`define BIT_PME_STATUS      16
`define BIT_PME_PENDING     17
`define CONTROL_WMASK       32'h0000_000F
`define RESET_WORD          32'h0000_0000
`define POSTED_CREDIT_VAL   32'h000C_0030
`define NONPOSTED_CRED_VAL  32'h0008_0001
`define ENH_CAP_HDR_VAL     32'h0001_0001
`endif

/* design/root_port_pkg.sv */
// Types for the root-port error and PME register block
package root_port_pkg;
    typedef struct packed {
        logic [3:0]  control;
        logic        pme_status;
        logic        pme_pending;
        logic [15:0] requester_id;
        logic        pme_irq;
        logic        serr;
        logic [31:0] rdata;
    } regs_state_t;
endpackage : root_port_pkg

/* design/pme_tracker.sv */
// PME status, pending and requester ID tracking
`timescale 1ns/100ps
`default_nettype none
`include "root_port_defines.svh"
module pme_tracker (
    input  wire logic        mclk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        pme_msg_in,
    input  wire logic [15:0] pme_rid_in,
    input  wire logic        status_clear_in,
    output logic             status_out,
    output logic             pending_out,
    output logic [15:0]      rid_out
);
    logic        status_q, status_d, pending_q, pending_d;
    logic [15:0] rid_q, rid_d;
    always_comb begin
        status_d  = status_q;
        pending_d = pending_q;
        rid_d     = rid_q;
        if (status_clear_in) begin
            status_d = pending_q;
            pending_d = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (pme_msg_in) begin
            status_d = 1'b1;
            rid_d    = pme_rid_in;
            if (status_q && !status_clear_in) begin
                pending_d = 1'b1;
            end
        end
    end
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            status_q  <= 1'b0;
            pending_q <= 1'b0;
            rid_q     <= 16'h0000;
        end else begin
            status_q  <= status_d;
            pending_q <= pending_d;
            rid_q     <= rid_d;
        end
    end
    assign status_out  = status_q;
    assign pending_out = pending_q;
    assign rid_out     = rid_q;
endmodule : pme_tracker
`default_nettype wire

/* design/root_port_error_pme_regs.sv */
// Root-port control, status and credit registers with error gating
`timescale 1ns/100ps
`default_nettype none
`include "root_port_defines.svh"
module root_port_error_pme_regs (
    input  wire logic        mclk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [11:0] cfg_addr_in,
    input  wire logic        cfg_wr_in,
    input  wire logic        cfg_rd_in,
    input  wire logic [31:0] cfg_wdata_in,
    input  wire logic        system_error_global_enable,
    input  wire logic        fatal_msg_in,
    input  wire logic        nonfatal_msg_in,
    input  wire logic        corr_msg_in,
    input  wire logic        pme_msg_in,
    input  wire logic [15:0] pme_rid_in,
    output logic [31:0]      cfg_rdata_out,
    output logic             pme_irq_out,
    output logic             serr_out
);
    root_port_pkg::regs_state_t s_q, s_d;
    logic        status_w, pending_w, clr_w, enable_rise;
    logic [15:0] rid_w;
    logic [31:0] rd_word;

    // Write-one-to-clear on the status flag
    assign clr_w = cfg_wr_in && (cfg_addr_in == `OFS_RP_STATUS)
                   && cfg_wdata_in[`BIT_PME_STATUS];

    pme_tracker u_pme (
        .mclk_in         (mclk_in),
        .sys_rst_in      (sys_rst_in),
        .pme_msg_in      (pme_msg_in),
        .pme_rid_in      (pme_rid_in),
        .status_clear_in (clr_w),
        .status_out      (status_w),
        .pending_out     (pending_w),
        .rid_out         (rid_w)
    );

    always_comb begin
        rd_word = `RESET_WORD;
        unique case (cfg_addr_in)
            `OFS_RP_CONTROL:     rd_word = {28'h000_0000, s_q.control};
            `OFS_RP_STATUS:      rd_word = {14'h0000, pending_w, status_w, rid_w};
            `OFS_POSTED_CREDIT:  rd_word = `POSTED_CREDIT_VAL;
            `OFS_NONPOSTED_CRED: rd_word = `NONPOSTED_CRED_VAL;
            `OFS_ENH_CAP_HDR:    rd_word = `ENH_CAP_HDR_VAL;
            default:             rd_word = `RESET_WORD;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.pme_status   = status_w;
        s_d.pme_pending  = pending_w;
        s_d.requester_id = rid_w;
        if (cfg_wr_in && cfg_addr_in == `OFS_RP_CONTROL) begin
            s_d.control = cfg_wdata_in[3:0];
        end
        if (cfg_rd_in) begin
            s_d.rdata = rd_word;
        end
        // Level request follows live status so a late enable still fires
        // A clear with a pending event keeps status up, so the request must not dip
        s_d.pme_irq = s_d.control[`BIT_PME_INT_ENABLE]
                      && (pme_msg_in || (status_w && !(clr_w && !pending_w)));
        s_d.serr = (fatal_msg_in && s_q.control[`BIT_FATAL_ENABLE] && system_error_global_enable)
                || (nonfatal_msg_in && s_q.control[`BIT_NONFATAL_ENABLE] && system_error_global_enable)
                || (corr_msg_in && s_q.control[`BIT_CORR_ENABLE]);
    end
    assign enable_rise = !s_q.control[`BIT_PME_INT_ENABLE] && s_d.control[`BIT_PME_INT_ENABLE];

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg_rdata_out = s_q.rdata;
    assign pme_irq_out   = s_q.pme_irq;
    assign serr_out      = s_q.serr;

    a_pme_irq_cause: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        $rose(status_w) && s_q.control[`BIT_PME_INT_ENABLE] |-> ##[0:1] pme_irq_out)
        else $error("PME interrupt missing");
    a_enable_rise: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        enable_rise && status_w && !clr_w |=> pme_irq_out)
        else $error("Enable rise did not interrupt");
    a_irq_gated: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        pme_irq_out |-> s_q.control[`BIT_PME_INT_ENABLE])
        else $error("Interrupt without enable");
    a_fatal_serr: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        fatal_msg_in && !nonfatal_msg_in && !corr_msg_in && !system_error_global_enable |=> !serr_out)
        else $error("Fatal serr without global enable");
    a_nonfatal_serr: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        nonfatal_msg_in && s_q.control[`BIT_NONFATAL_ENABLE] && system_error_global_enable |=> serr_out)
        else $error("Nonfatal serr missing");
    a_corr_serr: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        corr_msg_in && s_q.control[`BIT_CORR_ENABLE] |=> serr_out)
        else $error("Correctable serr missing");
    a_status_set: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        pme_msg_in |=> status_w && rid_w == $past(pme_rid_in))
        else $error("PME not captured");
    a_status_hold: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        status_w && !clr_w |=> status_w)
        else $error("Status dropped without clear");
    a_pending_set: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        pme_msg_in && status_w && !clr_w |=> pending_w)
        else $error("Pending not set");
    a_credit_read: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        cfg_rd_in && cfg_addr_in == `OFS_POSTED_CREDIT |=> cfg_rdata_out == `POSTED_CREDIT_VAL)
        else $error("Posted credit word wrong");
    c_pme_irq: cover property (@(posedge mclk_in) disable iff (sys_rst_in) $rose(pme_irq_out));
    c_pending: cover property (@(posedge mclk_in) disable iff (sys_rst_in) $rose(pending_w));
    c_serr:    cover property (@(posedge mclk_in) disable iff (sys_rst_in) serr_out);
endmodule : root_port_error_pme_regs
`default_nettype wire

/* testbench/msg_source.sv */
// Downstream message source model
`timescale 1ns/100ps
`default_nettype none
module msg_source (
    input  wire logic        clk_in,
    output logic [3:0]       msg_out,
    output logic [15:0]      rid_out
);
    initial begin
        msg_out = 4'h0;
        rid_out = 16'hFFFF;
    end
    // One pulse per message; id inverted after so a stale id never looks valid
    task automatic send(input int k, input logic [15:0] r);
        @(negedge clk_in);
        msg_out = 4'(4'h1 << k);
        rid_out = r;
        @(negedge clk_in);
        msg_out = 4'h0;
        rid_out = ~r;
    endtask : send
endmodule : msg_source
`default_nettype wire

/* testbench/root_port_error_pme_regs_test.sv */
// Self-checking bench for the root-port register block
`timescale 1ns/100ps
`default_nettype none
module root_port_error_pme_regs_test;
    logic        mclk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [11:0] addr = 12'h000;
    logic        wr = 1'b0, rd = 1'b0, glob = 1'b0;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0]  msg;
    logic [15:0] rid, r;
    logic        irq, serr;
    int mismatches = 0, n_tests = 0, cycles = 0, ctl = 0, st = 0, pend = 0, last = 0, v;
    always #50 mclk_in = ~mclk_in;
    root_port_error_pme_regs root_port_error_pme_regs_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .cfg_addr_in(addr), .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_wdata_in(wdata),
        .system_error_global_enable(glob), .fatal_msg_in(msg[2]), .nonfatal_msg_in(msg[1]),
        .corr_msg_in(msg[0]), .pme_msg_in(msg[3]), .pme_rid_in(rid), .cfg_rdata_out(rdata),
        .pme_irq_out(irq), .serr_out(serr));
    msg_source msg_source_inst (.clk_in(mclk_in), .msg_out(msg), .rid_out(rid));
    task automatic conclude();
        if (mismatches == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        @(negedge mclk_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk_in);
        wr = 1'b0;
    endtask : wr32
    task automatic rd32(input logic [11:0] a, input logic [31:0] exp);
        @(negedge mclk_in);
        addr = a;
        rd = 1'b1;
        @(negedge mclk_in);
        rd = 1'b0;
        chk(rdata, exp);
    endtask : rd32
    task automatic pme(input logic [15:0] id);
        if (st) pend = 1;
        st = 1;
        last = id;
        msg_source_inst.send(3, id);
    endtask : pme
    task automatic clr(input logic [31:0] d);
        wr32(12'h084, d);
        // Clearing with a pending event promotes it instead
        if (d[16] && pend) pend = 0;
        else if (d[16]) st = 0;
    endtask : clr
    task automatic rd_st();
        rd32(12'h084, {14'h0000, pend[0], st[0], last[15:0]});
    endtask : rd_st
    task automatic irq_is(input int e);
        @(negedge mclk_in);
        chk(irq, e);
    endtask : irq_is
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(negedge mclk_in);
        sys_rst_in = 1'b0;
        v = $urandom(23528);
        rd32(12'h080, 32'h0000_0000);
        rd_st();
        rd32(12'h0C4, 32'h000C_0030);
        rd32(12'h0C8, 32'h0008_0001);
        rd32(12'h0FC, 32'h0000_0000);
        v = $urandom;
        wr32(12'h080, v);
        rd32(12'h080, v & 15);
        wr32(12'h0C4, ~v);
        wr32(12'h0C8, v);
        rd32(12'h0C4, 32'h000C_0030);
        rd32(12'h0C8, 32'h0008_0001);
        for (int i = 0; i < 16; i++) begin
            glob = i[3];
            ctl = i & 7;
            wr32(12'h080, ctl);
            for (int k = 0; k < 3; k++) begin
                msg_source_inst.send(k, 16'h0000);
                chk(serr, ((ctl >> k) & 1) && (k == 0 || glob));
            end
        end
        wr32(12'h080, 0);
        r = 16'($urandom);
        pme(r);
        irq_is(0);
        rd_st();
        pme(~r);
        rd_st();
        wr32(12'h080, 8);
        irq_is(1);
        clr(0);
        rd_st();
        clr(32'h0001_0000);
        chk(irq, 1);
        rd_st();
        irq_is(1);
        clr(32'hFFFF_FFFF);
        irq_is(0);
        rd_st();
        pme(r ^ 16'h00FF);
        irq_is(1);
        wr32(12'h080, 0);
        irq_is(0);
        conclude();
    end
endmodule : root_port_error_pme_regs_test
`default_nettype wire
